// ---- core/ibs_pkg.sv ----
// Shared constants and carrier types for the two-wire bus sequencer.
// Assumes an APB master on mclk and a separate link clock for the pins.
package ibs_pkg;
   // Register byte addresses on the APB side
   localparam logic [7:0] ADDR_CTRL2  = 8'h00;
   localparam logic [7:0] ADDR_CTRL3  = 8'h04;
   localparam logic [7:0] ADDR_BUF    = 8'h08;
   localparam logic [7:0] ADDR_MODE   = 8'h0C;
   localparam logic [7:0] ADDR_STATUS = 8'h10;
   // Control two field positions
   localparam int BIT_GCALL   = 7;
   localparam int BIT_ACKSTAT = 6;
   localparam int BIT_ACK_VALUE_BIT   = 5;
   localparam int BIT_ACK_SEQUENCE_REQUEST   = 4;
   localparam int BIT_RECEIVE_REQUEST    = 3;
   localparam int BIT_STOP    = 2;
   localparam int BIT_RSTART  = 1;
   localparam int BIT_START   = 0;
   // Mode and status field positions
   localparam int BIT_MASTER  = 0;
   localparam int BIT_BUSY    = 0;
   localparam int BIT_PEND    = 1;
   // Reset values
   localparam logic [7:0] CTRL2_RST = 8'h00;
   localparam logic [6:0] CTRL3_RST = 7'h00;
   localparam logic [7:0] BUF_RST   = 8'h00;
   // Bus timing: link cycles per quarter bit period, falls before a slave stretch
   localparam logic [3:0] QUARTER_CYC  = 4'h4;
   localparam logic [3:0] STRETCH_FALL = 4'h7;
   localparam logic [2:0] LAST_BIT     = 3'h7;
   localparam logic [1:0] LAST_STEP    = 2'h3;

   // One-hot sequence request, only one of the five request bits set, ackVal rides along
   typedef struct packed {
      logic ackVal;  // Level sent during an acknowledge
      logic ack;
      logic recv;
      logic stop;
      logic rstart;
      logic start;
   } ibs_cmd_s;

   // Link sequencer states
   typedef enum logic [5:0] {
      ST_IDLE   = 6'b000001,
      ST_START  = 6'b000010,
      ST_RSTART = 6'b000100,
      ST_STOP   = 6'b001000,
      ST_RECV   = 6'b010000,
      ST_ACK    = 6'b100000
   } ibs_state_e;
endpackage

// ---- core/ibs_sync.sv ----
// Two flip-flop level synchroniser, one lane per bit.
// Assumes each lane is a level or toggle that is stable for several cycles.
module ibs_sync #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);
   logic [W-1:0] stage1;  // First stage, read only by the second

   // Two stages give the first one a full cycle to settle
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         stage1 <= '0;
         dout   <= '0;
      end else begin
         stage1 <= din;
         dout   <= stage1;
      end
   end
endmodule

// ---- core/ibs_sequencer.sv ----
// Two-wire master bus sequencer with APB control registers.
// Assumes APB on mclk and open-drain SCL/SDA pins served on linkClk.
//
// Added by the designer: the register offsets and register access over APB.
module ibs_sequencer (
   input  wire logic        mclk,
   input  wire logic        rst_n,
   input  wire logic        linkClk,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        sclIn,
   output logic             sclOut,
   output logic             sclOe,
   input  wire logic        sdaIn,
   output logic             sdaOut,
   output logic             sdaOe
);
   // ---------------- mclk domain ----------------
   logic [7:0]       ctrl2_reg;     // Control two, request bits self-clear
   logic [6:0]       ctrl3_reg;     // Control three, plain storage
   logic [7:0]       buf_reg;       // Shift data buffer
   logic             master_reg;    // Master mode select
   logic             pend_reg;      // Request in flight to the link side
   logic             cmdTgl_reg;    // Flips once per issued request
   ibs_pkg::ibs_cmd_s cmd_reg;      // Held stable while pend_reg is set
   logic             relTgl_reg;    // Flips to release a slave stretch
   logic             doneSeen_reg;  // Last done toggle seen
   logic [31:0]      prdata_reg;
   logic             pready_reg;
   logic             pslverr_reg;
   logic             doneSync;      // Done toggle from the link side
   logic             linkBusySync;  // Link sequencer busy level

   // ---------------- link domain ----------------
   ibs_pkg::ibs_state_e state_reg;
   logic [3:0]       qCnt_reg;      // Quarter period timer
   logic [1:0]       step_reg;      // Quarter within the current bit
   logic [2:0]       bitCnt_reg;    // Bit index while receiving
   logic [7:0]       shift_reg;     // Received byte, stable when idle
   logic             mSclLow_reg;   // Master holds SCL low
   logic             sdaOe_reg;
   logic             sclOe_reg;
   logic             doneTgl_reg;
   logic             busy_reg;
   logic             cmdSeen_reg;
   logic             relSeen_reg;
   logic             sclPrev_reg;
   logic [3:0]       fallCnt_reg;   // SCL falls counted in slave mode with the stretch bit set
   logic             hold_reg;      // Slave stretch active
   logic             cmdSync;
   logic             relSync;
   logic [1:0]       pinSync;       // {scl, sda} after two flops
   logic [1:0]       modeSync;      // {master, stretch} after two flops

   // Address decode and access qualification
   wire        setup    = psel & ~penable;
   wire        access   = psel & penable & pready_reg;
   wire [7:0]  addrLow  = paddr[7:0];
   wire        hitCtrl2 = addrLow == ibs_pkg::ADDR_CTRL2;
   wire        hitCtrl3 = addrLow == ibs_pkg::ADDR_CTRL3;
   wire        hitBuf   = addrLow == ibs_pkg::ADDR_BUF;
   wire        hitMode  = addrLow == ibs_pkg::ADDR_MODE;
   wire        hitStat  = addrLow == ibs_pkg::ADDR_STATUS;
   wire        hitAny   = hitCtrl2 | hitCtrl3 | hitBuf | hitMode | hitStat;
   wire        upperOk  = paddr[31:8] == 24'h000000;
   wire        mapped   = hitAny & upperOk;
   wire        wrCtrl2  = access & pwrite & mapped & hitCtrl2;
   wire        wrCtrl3  = access & pwrite & mapped & hitCtrl3;
   wire        wrBuf    = access & pwrite & mapped & hitBuf;
   wire        wrMode   = access & pwrite & mapped & hitMode;

   // Busy covers the whole round trip so nothing slips in
   wire        busy     = pend_reg | linkBusySync;
   wire        doneEvt  = doneSync ^ doneSeen_reg;

   // Request picking: one request at a time, start first
   wire        wStart   = pwdata[ibs_pkg::BIT_START];
   wire        wRstart  = pwdata[ibs_pkg::BIT_RSTART] & ~wStart;
   wire        wStop    = pwdata[ibs_pkg::BIT_STOP] & ~wStart & ~pwdata[ibs_pkg::BIT_RSTART];
   wire        wRecv    = pwdata[ibs_pkg::BIT_RECEIVE_REQUEST] & ~|pwdata[2:0];
   wire        wAck     = pwdata[ibs_pkg::BIT_ACK_SEQUENCE_REQUEST] & ~|pwdata[3:0];
   wire        wAnyReq  = |pwdata[4:0];
   // Requests only taken in master mode and when idle
   wire        reqOk    = wrCtrl2 & master_reg & ~busy & wAnyReq;
   wire        bufOk    = wrBuf & ~busy;

   // Next value of control two
   logic [7:0] ctrl2_next;
   always_comb begin
      ctrl2_next = ctrl2_reg;
      if (doneEvt) begin
         // Self-clearing bits drop only once the sequence has finished
         ctrl2_next[4:0] = 5'h00;
      end
      if (wrCtrl2) begin
         ctrl2_next[ibs_pkg::BIT_GCALL] = pwdata[ibs_pkg::BIT_GCALL];
         if (!busy) begin
            // Ack level is kept steady during a sequence
            ctrl2_next[ibs_pkg::BIT_ACK_VALUE_BIT] = pwdata[ibs_pkg::BIT_ACK_VALUE_BIT];
         end
         if (!master_reg) begin
            // Slave mode: the start bit is a plain stretch enable
            ctrl2_next[ibs_pkg::BIT_START] = wStart;
         end else if (reqOk) begin
            ctrl2_next[4:0] = {wAck, wRecv, wStop, wRstart, wStart};
         end
      end
   end

   // Request handed to the link side; ack level sampled with it
   wire ibs_pkg::ibs_cmd_s cmdNew = '{ackVal: pwdata[ibs_pkg::BIT_ACK_VALUE_BIT], ack: wAck,
                                      recv: wRecv, stop: wStop, rstart: wRstart,
                                      start: wStart};

   // Control and data registers
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl2_reg  <= ibs_pkg::CTRL2_RST;
         ctrl3_reg  <= ibs_pkg::CTRL3_RST;
         master_reg <= 1'b0;
         buf_reg    <= ibs_pkg::BUF_RST;
      end else begin
         ctrl2_reg <= ctrl2_next;
         if (wrCtrl3) begin
            ctrl3_reg <= pwdata[6:0];
         end
         if (wrMode && !busy) begin
            // Mode changes mid-sequence would corrupt the pins
            master_reg <= pwdata[ibs_pkg::BIT_MASTER];
         end
         if (bufOk) begin
            buf_reg <= pwdata[7:0];
         end else if (doneEvt && cmd_reg.recv) begin
            // Link byte is stable until the next request
            buf_reg <= shift_reg;
         end
      end
   end

   // Request handshake toward the link side
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         pend_reg     <= 1'b0;
         cmdTgl_reg   <= 1'b0;
         cmd_reg      <= '0;
         doneSeen_reg <= 1'b0;
         relTgl_reg   <= 1'b0;
      end else begin
         doneSeen_reg <= doneSync;
         if (reqOk) begin
            pend_reg   <= 1'b1;
            cmd_reg    <= cmdNew;
            cmdTgl_reg <= ~cmdTgl_reg;
         end else if (doneEvt) begin
            pend_reg <= 1'b0;
         end
         if (bufOk && !master_reg) begin
            // Servicing the buffer lets a stretched clock go
            relTgl_reg <= ~relTgl_reg;
         end
      end
   end

   // Read data selection
   wire [31:0] rdCtrl2 = {24'h000000, ctrl2_reg[7], 1'b0, ctrl2_reg[5:0]};
   wire [31:0] rdCtrl3 = {25'h0000000, ctrl3_reg};
   wire [31:0] rdBuf   = {24'h000000, buf_reg};
   wire [31:0] rdMode  = {31'h00000000, master_reg};
   wire [31:0] rdStat  = {30'h00000000, pend_reg, busy};
   wire [31:0] rdMux   = hitCtrl2 ? rdCtrl2 :
                         hitCtrl3 ? rdCtrl3 :
                         hitBuf   ? rdBuf   :
                         hitMode  ? rdMode  :
                         hitStat  ? rdStat  : 32'h00000000;

   // APB answer: ready in the first access cycle, error on unmapped
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         prdata_reg  <= 32'h00000000;
         pready_reg  <= 1'b0;
         pslverr_reg <= 1'b0;
      end else begin
         pready_reg  <= setup;
         pslverr_reg <= setup & ~mapped;
         if (setup && !pwrite) begin
            prdata_reg <= mapped ? rdMux : 32'h00000000;
         end
      end
   end

   // Crossings into mclk
   ibs_sync #(.W(2)) uSyncToM (
      .clk   (mclk),
      .rst_n (rst_n),
      .din   ({doneTgl_reg, busy_reg}),
      .dout  ({doneSync, linkBusySync})
   );

   // Crossings into the link domain; mode bits are quasi-static
   ibs_sync #(.W(6)) uSyncToL (
      .clk   (linkClk),
      .rst_n (rst_n),
      .din   ({cmdTgl_reg, relTgl_reg, sclIn, sdaIn, master_reg,
               ctrl2_reg[ibs_pkg::BIT_START]}),
      .dout  ({cmdSync, relSync, pinSync, modeSync})
   );

   // Link side sequencing
   wire cmdEvt   = cmdSync ^ cmdSeen_reg;
   wire tick     = qCnt_reg == (ibs_pkg::QUARTER_CYC - 4'h1);
   wire lastStep = step_reg == ibs_pkg::LAST_STEP;
   wire sdaPin   = pinSync[0];

   // Quarter period timer, restarted by each new request
   always_ff @(posedge linkClk or negedge rst_n) begin
      if (!rst_n) begin
         qCnt_reg <= 4'h0;
      end else if (cmdEvt || tick || state_reg == ibs_pkg::ST_IDLE) begin
         qCnt_reg <= 4'h0;
      end else begin
         qCnt_reg <= qCnt_reg + 4'h1;
      end
   end

   // Pin sequencer: each sequence walks quarter steps on ticks
   always_ff @(posedge linkClk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg   <= ibs_pkg::ST_IDLE;
         step_reg    <= 2'h0;
         bitCnt_reg  <= 3'h0;
         shift_reg   <= 8'h00;
         mSclLow_reg <= 1'b0;
         sdaOe_reg   <= 1'b0;
         doneTgl_reg <= 1'b0;
         busy_reg    <= 1'b0;
         cmdSeen_reg <= 1'b0;
      end else begin
         cmdSeen_reg <= cmdSync;
         case (state_reg)
            ibs_pkg::ST_IDLE: begin
               // Receiver stays idle with no request
               step_reg   <= 2'h0;
               bitCnt_reg <= 3'h0;
               if (cmdEvt) begin
                  busy_reg <= 1'b1;
                  if (cmd_reg.start) begin
                     state_reg <= ibs_pkg::ST_START;
                  end else if (cmd_reg.rstart) begin
                     state_reg <= ibs_pkg::ST_RSTART;
                  end else if (cmd_reg.stop) begin
                     state_reg <= ibs_pkg::ST_STOP;
                  end else if (cmd_reg.recv) begin
                     state_reg <= ibs_pkg::ST_RECV;
                  end else begin
                     state_reg <= ibs_pkg::ST_ACK;
                  end
               end
            end
            ibs_pkg::ST_START: if (tick) begin
               // Data falls while clock is high, then clock falls
               step_reg <= step_reg + 2'h1;
               if (step_reg == 2'h0) begin
                  sdaOe_reg <= 1'b1;
               end else begin
                  mSclLow_reg <= 1'b1;
                  state_reg   <= ibs_pkg::ST_IDLE;
                  busy_reg    <= 1'b0;
                  doneTgl_reg <= ~doneTgl_reg;
               end
            end
            ibs_pkg::ST_RSTART: if (tick) begin
               // Release data, raise clock, then a fresh start
               step_reg <= step_reg + 2'h1;
               case (step_reg)
                  2'h0: sdaOe_reg <= 1'b0;
                  2'h1: mSclLow_reg <= 1'b0;
                  2'h2: sdaOe_reg <= 1'b1;
                  default: begin
                     mSclLow_reg <= 1'b1;
                     state_reg   <= ibs_pkg::ST_IDLE;
                     busy_reg    <= 1'b0;
                     doneTgl_reg <= ~doneTgl_reg;
                  end
               endcase
            end
            ibs_pkg::ST_STOP: if (tick) begin
               // Data low, clock released, then data rises
               step_reg <= step_reg + 2'h1;
               case (step_reg)
                  2'h0: sdaOe_reg <= 1'b1;
                  2'h1: mSclLow_reg <= 1'b0;
                  default: begin
                     sdaOe_reg   <= 1'b0;
                     state_reg   <= ibs_pkg::ST_IDLE;
                     busy_reg    <= 1'b0;
                     doneTgl_reg <= ~doneTgl_reg;
                  end
               endcase
            end
            ibs_pkg::ST_RECV: if (tick) begin
               // Sample each bit in the middle of the clock high time
               step_reg <= step_reg + 2'h1;
               case (step_reg)
                  2'h0: sdaOe_reg <= 1'b0;
                  2'h1: mSclLow_reg <= 1'b0;
                  2'h2: shift_reg <= {shift_reg[6:0], sdaPin};
                  default: begin
                     mSclLow_reg <= 1'b1;
                     bitCnt_reg  <= bitCnt_reg + 3'h1;
                     if (bitCnt_reg == ibs_pkg::LAST_BIT) begin
                        state_reg   <= ibs_pkg::ST_IDLE;
                        busy_reg    <= 1'b0;
                        doneTgl_reg <= ~doneTgl_reg;
                     end
                  end
               endcase
            end
            ibs_pkg::ST_ACK: if (tick) begin
               // Present the ack level, pulse the clock, release data
               step_reg <= step_reg + 2'h1;
               case (step_reg)
                  2'h0: sdaOe_reg <= ~cmd_reg.ackVal;
                  2'h1: mSclLow_reg <= 1'b0;
                  2'h2: mSclLow_reg <= 1'b1;
                  default: begin
                     sdaOe_reg   <= 1'b0;
                     state_reg   <= ibs_pkg::ST_IDLE;
                     busy_reg    <= 1'b0;
                     doneTgl_reg <= ~doneTgl_reg;
                  end
               endcase
            end
            default: begin
               state_reg <= ibs_pkg::ST_IDLE;
               busy_reg  <= 1'b0;
            end
         endcase
      end
   end

   // Slave stretch: hold SCL low after a byte until software services it
   wire sclFall  = sclPrev_reg & ~pinSync[1];
   wire stretchOn = ~modeSync[1] & modeSync[0];
   wire relEvt   = relSync ^ relSeen_reg;
   always_ff @(posedge linkClk or negedge rst_n) begin
      if (!rst_n) begin
         sclPrev_reg <= 1'b1;
         fallCnt_reg <= 4'h0;
         hold_reg    <= 1'b0;
         relSeen_reg <= 1'b0;
      end else begin
         sclPrev_reg <= pinSync[1];
         relSeen_reg <= relSync;
         if (!stretchOn) begin
            // Stretch bit low: never hold the clock
            hold_reg    <= 1'b0;
            fallCnt_reg <= 4'h0;
         end else if (relEvt) begin
            hold_reg <= 1'b0;
         end else if (sclFall) begin
            if (fallCnt_reg == ibs_pkg::STRETCH_FALL) begin
               hold_reg    <= 1'b1;
               fallCnt_reg <= 4'h0;
            end else begin
               fallCnt_reg <= fallCnt_reg + 4'h1;
            end
         end
      end
   end

   // Pin drivers; open drain so only low is ever driven
   wire sclDrive = modeSync[1] ? mSclLow_reg : hold_reg;
   always_ff @(posedge linkClk or negedge rst_n) begin
      if (!rst_n) begin
         sclOe_reg <= 1'b0;
      end else begin
         sclOe_reg <= sclDrive;
      end
   end

   assign prdata  = prdata_reg;
   assign pready  = pready_reg;
   assign pslverr = pslverr_reg;
   assign sclOe   = sclOe_reg;
   assign sdaOe   = sdaOe_reg;
   assign sclOut  = 1'b0;
   assign sdaOut  = 1'b0;
endmodule

// ---- tb/ibs_seq_assertions.sv ----
// Checker for the sequencer's APB answers and the two-wire pin drive.
// Assumes it is bound onto ibs_sequencer and sees only its ports.
module ibs_seq_assertions (
   input wire logic        mclk,
   input wire logic        rst_n,
   input wire logic        linkClk,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        sclIn,
   input wire logic        sclOut,
   input wire logic        sclOe,
   input wire logic        sdaIn,
   input wire logic        sdaOut,
   input wire logic        sdaOe
);
   // Answer comes in the first access cycle, never later
   AST_PREADY_ONE: assert property (@(posedge mclk) disable iff (!rst_n)
      psel && !penable |=> pready) else $error("pready not one cycle after setup");
   // Answer stands one cycle only, so a held request is not taken twice
   AST_PREADY_PULSE: assert property (@(posedge mclk) disable iff (!rst_n)
      pready |=> !pready) else $error("pready held too long");
   // Addresses above the register page are refused
   AST_ERR_MAP: assert property (@(posedge mclk) disable iff (!rst_n)
      pready && paddr[31:8] != 24'h0 |-> pslverr) else $error("unmapped not refused");
   // The mode register is always accepted
   AST_ERR_OK: assert property (@(posedge mclk) disable iff (!rst_n)
      pready && paddr == {24'h0, ibs_pkg::ADDR_MODE} |-> !pslverr)
      else $error("mapped address refused");
   // Registers are at most one byte wide, upper read bits stay clear
   AST_READ_UPPER: assert property (@(posedge mclk) disable iff (!rst_n)
      pready && !pwrite |-> prdata[31:8] == 24'h0) else $error("upper read bits set");
   // Open drain: the pins may only ever be pulled low
   AST_DRIVE_LOW: assert property (@(posedge mclk) disable iff (!rst_n)
      !sclOut && !sdaOut) else $error("pin driven high");
   // Data pulled low with clock high is a start, clock follows within nine link cycles
   AST_START_ORDER: assert property (@(posedge linkClk) disable iff (!rst_n)
      $rose(sdaOe) && !sclOe |-> ##[1:9] sclOe) else $error("clock not low after start");
   // Data released with clock high is a stop, the bus then stays free for four link cycles
   AST_STOP_FREE: assert property (@(posedge linkClk) disable iff (!rst_n)
      $fell(sdaOe) && !sclOe |-> (!sdaOe && !sclOe) [*4]) else $error("bus not free after stop");
   // Main scenarios reached
   COV_START: cover property (@(posedge linkClk) disable iff (!rst_n) $rose(sdaOe) && !sclOe);
   COV_ERR: cover property (@(posedge mclk) disable iff (!rst_n) pslverr);
   COV_STOP: cover property (@(posedge linkClk) disable iff (!rst_n) $fell(sdaOe) && !sclOe);
endmodule

bind ibs_sequencer ibs_seq_assertions chk_u (.mclk(mclk), .rst_n(rst_n), .linkClk(linkClk),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .sclIn(sclIn), .sclOut(sclOut),
   .sclOe(sclOe), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe));

// ---- tb/ibs_bus_model.sv ----
// Behavioural slave on the two-wire bus, with pull-ups on both lines.
// Assumes open-drain enables from the sequencer; the bench may pull clock as a master.
module ibs_bus_model #(
   parameter logic [7:0] TX_BYTE = 8'hA5
) (
   input  wire logic sclOe,
   input  wire logic sdaOe,
   input  wire logic masterSclLow,
   output logic      sclLine,
   output logic      sdaLine,
   output int        startCnt,
   output int        stopCnt,
   output logic      lastBit
);
   timeunit 1ns;
   timeprecision 1ps;
   int   bitCnt;  // Bits sent since the last start, 8 means released
   logic armed;   // A clock rise was seen since the start
   logic slvLow;  // Slave pulls data low
   // Released lines float to the pull-up level, never a stale value
   assign sclLine = ~((sclOe === 1'b1) | (masterSclLow === 1'b1));
   assign sdaLine = ~((sdaOe === 1'b1) | slvLow);
   // Slave sends its byte MSB first after a start
   assign slvLow  = (bitCnt < 8) && !TX_BYTE[3'(7 - bitCnt)];
   initial begin
      startCnt = 0;
      stopCnt = 0;
      bitCnt = 8;
      armed = 1'b0;
      lastBit = 1'b1;
   end
   // Start or repeated start: restart the byte
   always @(negedge sdaLine) if (sclLine === 1'b1 && $time > 0) begin
      startCnt++;
      bitCnt = 0;
      armed = 1'b0;
   end
   // Stop condition
   always @(posedge sdaLine) if (sclLine === 1'b1 && $time > 0) stopCnt++;
   // Data is read while clock is high, also the acknowledge level
   always @(posedge sclLine) begin
      lastBit = sdaLine;
      armed = 1'b1;
   end
   // Next bit is set up only while clock is low, so no false start or stop
   always @(negedge sclLine) if (armed && bitCnt < 8) bitCnt++;
endmodule

// ---- tb/ibs_sequencer_bench.sv ----
// Bench for the two-wire sequencer: register table, then bus sequences.
// Assumes the bus model and the checker are compiled before it.
module ibs_sequencer_bench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [31:0] C2 = {24'h0, ibs_pkg::ADDR_CTRL2};
   localparam logic [31:0] C3 = {24'h0, ibs_pkg::ADDR_CTRL3};
   localparam logic [31:0] BF = {24'h0, ibs_pkg::ADDR_BUF};
   localparam logic [31:0] MD = {24'h0, ibs_pkg::ADDR_MODE};
   typedef struct {logic [31:0] a; logic [31:0] d; logic [31:0] e; logic err;} ibs_row_s;
   logic        mclk, rst_n, linkClk, psel, penable, pwrite, rerr;
   logic [31:0] paddr, pwdata, prdata, rdat;
   logic        pready, pslverr, sclOe, sdaOe, sclLine, sdaLine, masterSclLow, lastBit;
   int          startCnt, stopCnt, mismatches, cmp_count;
   // Ordinary register cases: address, write, expected read, refused
   ibs_row_s rows [7] = '{
      '{C3, 32'hFF, 32'h7F, 1'b0},
      '{C2, 32'h9E, 32'h80, 1'b0},
      '{C2, 32'h01, 32'h01, 1'b0},
      '{C2, 32'h00, 32'h00, 1'b0},
      '{32'h14, 32'hFF, 32'h00, 1'b1},
      '{32'h100, 32'hFF, 32'h00, 1'b1},
      '{MD, 32'h01, 32'h01, 1'b0}};
   // Clocks: link clock offset so the two never line up
   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end
   initial begin
      linkClk = 1'b0;
      #7;
      forever #15 linkClk = ~linkClk;
   end
   ibs_sequencer dut_u (.mclk(mclk), .rst_n(rst_n), .linkClk(linkClk), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .sclIn(sclLine), .sclOut(), .sclOe(sclOe),
      .sdaIn(sdaLine), .sdaOut(), .sdaOe(sdaOe));
   ibs_bus_model bus_u (.sclOe(sclOe), .sdaOe(sdaOe), .masterSclLow(masterSclLow),
      .sclLine(sclLine), .sdaLine(sdaLine), .startCnt(startCnt), .stopCnt(stopCnt),
      .lastBit(lastBit));
   // Compare and count
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %0t got %h want %h", $time, got, exp);
      end
   endtask
   // One APB transfer, held until pready; one idle cycle after keeps drives apart
   task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do begin
         @(posedge mclk);
      end while (pready !== 1'b1);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge mclk);
   endtask
   task automatic rdChk(input logic [31:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rdat, e);
   endtask
   // Poll control two until the request bits clear, under a bound
   task automatic waitClr(input logic [31:0] m);
      for (int i = 0; i < 400; i++) begin
         apb(1'b0, C2, 32'h0);
         if ((rdat & m) === 32'h0) break;
      end
   endtask
   // Bench acts as a bus master pulling the clock eight times
   task automatic sclPulses();
      repeat (8) begin
         masterSclLow <= 1'b1;
         repeat (8) @(posedge mclk);
         masterSclLow <= 1'b0;
         repeat (8) @(posedge mclk);
      end
   endtask
   task automatic done(input string s);
      $display("test %s done", s);
   endtask
   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // Watchdog: whole run needs well under a millisecond
   initial begin
      #1000000;
      mismatches++;
      end_sim();
   end
   // Main sequence
   initial begin
      mismatches = 0;
      cmp_count = 0;
      {rst_n, psel, penable, pwrite, masterSclLow} = 5'h0;
      paddr = 32'h0;
      pwdata = 32'h0;
      repeat (12) @(posedge mclk);
      rst_n <= 1'b1;
      @(posedge mclk);
      rdChk(C2, 32'h0);
      rdChk(C3, 32'h0);
      foreach (rows[i]) begin
         apb(1'b1, rows[i].a, rows[i].d);
         apb(1'b0, rows[i].a, 32'h0);
         chk(rdat, rows[i].e);
         chk({31'h0, rerr}, {31'h0, rows[i].err});
      end
      done("registers");
      // Start in master mode; bit stays set until the bus is done
      apb(1'b1, C2, 32'h01);
      rdChk(C2, 32'h01);
      waitClr(32'h01);
      chk(rdat, 32'h0);
      chk(startCnt, 1);
      done("start");
      // Receive is long: a stop write meanwhile must be dropped
      apb(1'b1, C2, 32'h08);
      apb(1'b1, C2, 32'h04);
      rdChk(C2, 32'h08);
      waitClr(32'h08);
      rdChk(BF, 32'hA5);
      chk(stopCnt, 0);
      done("receive");
      // Acknowledge sends the chosen level, then the request clears
      for (int v = 1; v >= 0; v--) begin
         apb(1'b1, C2, v ? 32'h30 : 32'h10);
         waitClr(32'h10);
         chk({31'h0, rdat[ibs_pkg::BIT_ACK_SEQUENCE_REQUEST]}, 32'h0);
         chk({31'h0, lastBit}, 32'(v));
      end
      done("ack");
      apb(1'b1, C2, 32'h02);
      waitClr(32'h02);
      chk(startCnt, 2);
      apb(1'b1, C2, 32'h04);
      apb(1'b1, BF, 32'h55);
      waitClr(32'h04);
      rdChk(BF, 32'hA5);
      chk(stopCnt, 1);
      chk({sclLine, sdaLine}, 32'h3);
      done("restart stop");
      // Reset in mid-run restores the registers
      apb(1'b1, C3, 32'h55);
      rst_n <= 1'b0;
      repeat (3) @(posedge mclk);
      rst_n <= 1'b1;
      @(posedge mclk);
      rdChk(C3, 32'h0);
      rdChk(MD, 32'h0);
      done("reset");
      // Slave: stretch after eight falls only when enabled, a buffer write frees it
      for (int en = 1; en >= 0; en--) begin
         apb(1'b1, C2, 32'(en));
         sclPulses();
         repeat (20) @(posedge mclk);
         chk({31'h0, sclOe}, 32'(en));
         apb(1'b1, BF, 32'h11);
         repeat (20) @(posedge mclk);
         chk({31'h0, sclOe}, 32'h0);
      end
      done("stretch");
      end_sim();
   end
endmodule
